// ==== rtl/lpm_pkg.sv ====
package lpm_pkg;
   // apb register byte offsets
   localparam logic [7:0] CTRL_OFFS = 8'h00;
   localparam logic [7:0] STATUS_OFFS = 8'h04;
   localparam logic [7:0] POWER_OFFS = 8'h08;
   // control register field positions and reset values
   localparam int CTRL_D1_BIT = 0;
   localparam int CTRL_D2_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // status register field positions
   localparam int ST_LINK_LSB = 0;
   localparam int ST_TURNOFF_BIT = 2;
   localparam int ST_MSI_BIT = 3;
   localparam int ST_MSIX_BIT = 4;
   localparam int ST_INTXDIS_BIT = 5;
   localparam int ST_MODE_LSB = 6;
   // command register interrupt-disable bit position
   localparam int CMD_INTXDIS_BIT = 10;
   // number of functions
   localparam int NUM_FUNC = 4;
   // function power states
   typedef enum logic [1:0]
   {
      PWR_D0 = 2'b00,
      PWR_D1 = 2'b01,
      PWR_D2 = 2'b10,
      PWR_D3HOT = 2'b11
   } lpm_pwr_t;
   // link states
   typedef enum logic [1:0]
   {
      LNK_DOWN = 2'b00,
      LNK_L0 = 2'b01,
      LNK_L1 = 2'b10,
      LNK_L23 = 2'b11
   } lpm_link_t;
   // interrupt modes
   typedef enum logic [1:0]
   {
      IRQ_INTX = 2'b00,
      IRQ_MSI = 2'b01,
      IRQ_MSIX = 2'b10,
      IRQ_BOTH = 2'b11
   } lpm_irq_t;
endpackage

// ==== rtl/lpm_ctrl.sv ====
`timescale 1ns/1ns
module lpm_ctrl
#(
   parameter int NUM_FUNC = lpm_pkg::NUM_FUNC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link events from the core
   input wire logic trainDone,
   input wire logic turnoffMsg,
   input wire logic l1AckDllp,
   output logic l1ReqDllp,
   output logic pmeToAckSend,
   output lpm_pkg::lpm_link_t linkState,
   output logic ifClosed,
   // host configuration writes
   input wire logic hostPmWr,
   input wire logic [1:0] hostPmFunc,
   input wire logic [1:0] hostPmState,
   input wire logic hostIrqWr,
   input wire logic hostMsiEn,
   input wire logic hostMsixEn,
   input wire logic [15:0] hostCmd,
   // requester request stream from user
   input wire logic reqValid,
   input wire logic reqLast,
   input wire logic linkReqReady,
   output logic req_stream_ready,
   // power state and turnoff handshake
   output logic [2*NUM_FUNC-1:0] funcPowerState,
   output logic turnoff_notice,
   input wire logic turnoffAck,
   // interrupt mode and requests
   output logic msiEnable,
   output logic msixEnable,
   output lpm_pkg::lpm_irq_t irqMode,
   input wire logic userIntxReq,
   input wire logic userMsiReq,
   output logic intxMsgSend,
   output logic msiWriteSend
);
   // all state of the block
   typedef struct packed
   {
      lpm_pkg::lpm_link_t link;
      logic [2*NUM_FUNC-1:0] pwr;
      logic [1:0] ctrl;
      logic msi;
      logic msix;
      logic intxDis;
      logic notice;
      logic toAck;
      logic l1Req;
      logic l1Pend;
      logic inPkt;
      logic intxSent;
      logic msiSent;
      logic [31:0] rdata;
   } lpm_state_t;

   lpm_state_t cur;
   lpm_state_t next_cur;
   logic allD0; // every function in D0
   logic allLow; // every function in a state that allows L1
   logic rdUnmapped; // address decode miss
   logic [31:0] rdMux; // read data before capture

   // power state summaries used by stall and l1 entry
   always_comb
   begin
      allD0 = 1'b1;
      allLow = 1'b1;
      for (int f = 0; f < NUM_FUNC; f++)
      begin
         if (cur.pwr[2*f +: 2] != lpm_pkg::PWR_D0)
            allD0 = 1'b0;
         // only d3hot, or d1/d2 where software marked them supported
         if (!((cur.pwr[2*f +: 2] == lpm_pkg::PWR_D3HOT)
               || (cur.pwr[2*f +: 2] == lpm_pkg::PWR_D1 && cur.ctrl[lpm_pkg::CTRL_D1_BIT])
               || (cur.pwr[2*f +: 2] == lpm_pkg::PWR_D2 && cur.ctrl[lpm_pkg::CTRL_D2_BIT])))
            allLow = 1'b0;
      end
   end

   // register read decode
   always_comb
   begin
      rdMux = 32'h0000_0000;
      rdUnmapped = 1'b0;
      case (paddr)
         lpm_pkg::CTRL_OFFS: rdMux[1:0] = cur.ctrl;
         lpm_pkg::STATUS_OFFS:
         begin
            rdMux[lpm_pkg::ST_LINK_LSB +: 2] = cur.link;
            rdMux[lpm_pkg::ST_TURNOFF_BIT] = cur.notice;
            rdMux[lpm_pkg::ST_MSI_BIT] = cur.msi;
            rdMux[lpm_pkg::ST_MSIX_BIT] = cur.msix;
            rdMux[lpm_pkg::ST_INTXDIS_BIT] = cur.intxDis;
            rdMux[lpm_pkg::ST_MODE_LSB +: 2] = {cur.msix, cur.msi};
         end
         lpm_pkg::POWER_OFFS: rdMux[2*NUM_FUNC-1:0] = cur.pwr;
         default: rdUnmapped = 1'b1;
      endcase
   end

   // next state of the whole block
   always_comb
   begin
      next_cur = cur;
      next_cur.toAck = 1'b0;
      next_cur.l1Req = 1'b0;
      next_cur.intxSent = 1'b0;
      next_cur.msiSent = 1'b0;
      // apb: capture read data in setup, write in access phase
      if (psel && !penable)
         next_cur.rdata = rdMux;
      if (psel && penable && pwrite && paddr == lpm_pkg::CTRL_OFFS)
         next_cur.ctrl = pwdata[1:0];
      // host configuration writes are the only path to these bits
      if (hostPmWr)
         next_cur.pwr[2*hostPmFunc +: 2] = hostPmState;
      if (hostIrqWr)
      begin
         next_cur.msi = hostMsiEn;
         next_cur.msix = hostMsixEn;
         next_cur.intxDis = hostCmd[lpm_pkg::CMD_INTXDIS_BIT];
      end
      // track an accepted packet so its tail is still taken
      if (reqValid && req_stream_ready)
         next_cur.inPkt = !reqLast;
      // turnoff handshake: notice until acknowledge, drop next cycle
      if (cur.notice && turnoffAck)
      begin
         next_cur.notice = 1'b0;
         next_cur.toAck = 1'b1;
      end
      else if (turnoffMsg && cur.link != lpm_pkg::LNK_L23 && !cur.notice)
         next_cur.notice = 1'b1;
      // link state machine
      case (cur.link)
         lpm_pkg::LNK_DOWN:
            if (trainDone)
               next_cur.link = lpm_pkg::LNK_L0;
         lpm_pkg::LNK_L0:
         begin
            if (cur.toAck)
               next_cur.link = lpm_pkg::LNK_L23;
            else if (allLow && !cur.inPkt && !cur.notice)
            begin
               // request l1 once, then wait for the partner's answer
               if (!cur.l1Pend)
               begin
                  next_cur.l1Req = 1'b1;
                  next_cur.l1Pend = 1'b1;
               end
               else if (l1AckDllp)
               begin
                  next_cur.link = lpm_pkg::LNK_L1;
                  next_cur.l1Pend = 1'b0;
               end
            end
            else
               next_cur.l1Pend = 1'b0;
         end
         lpm_pkg::LNK_L1:
            if (cur.toAck)
               next_cur.link = lpm_pkg::LNK_L23;
            else if (!allLow)
               next_cur.link = lpm_pkg::LNK_L0;
         lpm_pkg::LNK_L23: next_cur.link = lpm_pkg::LNK_L23;
         default: next_cur.link = lpm_pkg::LNK_DOWN;
      endcase
      // interrupt controller: msi write or gated legacy, never msix
      if (cur.link != lpm_pkg::LNK_L23)
      begin
         if (cur.msi && userMsiReq)
            next_cur.msiSent = 1'b1;
         else if (!cur.msi && !cur.msix && userIntxReq && !cur.intxDis)
            next_cur.intxSent = 1'b1;
      end
   end

   // register the whole state
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cur <= '0;
         cur.link <= lpm_pkg::LNK_DOWN;
         cur.ctrl <= lpm_pkg::CTRL_RESET;
      end
      else
         cur <= next_cur;
   end

   // outputs
   assign prdata = cur.rdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & rdUnmapped;
   assign linkState = cur.link;
   assign l1ReqDllp = cur.l1Req;
   assign pmeToAckSend = cur.toAck;
   assign ifClosed = (cur.link == lpm_pkg::LNK_L23);
   assign funcPowerState = cur.pwr;
   assign turnoff_notice = cur.notice;
   assign msiEnable = cur.msi;
   assign msixEnable = cur.msix;
   assign irqMode = lpm_pkg::lpm_irq_t'({cur.msix, cur.msi});
   assign intxMsgSend = cur.intxSent;
   assign msiWriteSend = cur.msiSent;
   // stall new packets outside D0 but finish one in progress
   assign req_stream_ready = linkReqReady && !ifClosed && (allD0 || cur.inPkt);

   // notice holds until the acknowledge is seen
   sequence noticeUnacked;
      turnoff_notice && !turnoffAck;
   endsequence
   sequence ackSeen;
      turnoff_notice && turnoffAck;
   endsequence
   notice_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      noticeUnacked |=> turnoff_notice)
      else $error("turnoff notice dropped without acknowledge");
   notice_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ackSeen |=> !turnoff_notice && pmeToAckSend)
      else $error("notice not cleared after acknowledge");
   toack_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      pmeToAckSend |-> $past(turnoff_notice) && $past(turnoffAck))
      else $error("turnoff acknowledge sent without handshake");
   notice_raise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      turnoffMsg && !turnoff_notice && !ifClosed && !pmeToAckSend |=> turnoff_notice)
      else $error("turnoff message did not raise notice");
   l23_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      pmeToAckSend && linkState != lpm_pkg::LNK_DOWN |=> ifClosed ##1 ifClosed)
      else $error("link not closed after turnoff acknowledge");
   stall_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      req_stream_ready |-> (funcPowerState == '0) || cur.inPkt)
      else $error("request accepted outside D0");
   open_pkt_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      cur.inPkt && linkReqReady && !ifClosed |-> req_stream_ready)
      else $error("packet in flight was stalled");
   l1_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      linkState == lpm_pkg::LNK_L0 ##1 linkState == lpm_pkg::LNK_L1 |-> $past(allLow))
      else $error("l1 entered without low power state");
   mode_decode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      irqMode == lpm_pkg::IRQ_MSIX |-> msixEnable && !msiEnable)
      else $error("interrupt mode decode wrong");
   intx_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      intxMsgSend |-> !$past(cur.intxDis) && !$past(msiEnable) && $past(userIntxReq))
      else $error("legacy interrupt sent while blocked");
   msi_send_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      msiEnable && userMsiReq && !ifClosed |=> msiWriteSend)
      else $error("msi request not sent");
   mirror_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      hostIrqWr |=> msiEnable == $past(hostMsiEn) && msixEnable == $past(hostMsixEn))
      else $error("enable outputs do not mirror host write");
endmodule

// ==== tb/lpm_user_model.sv ====
`timescale 1ns/1ns
// user application side of the turnoff handshake
module lpm_user_model
#(
   parameter int ACK_DELAY = 5
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // handshake
   input wire logic turnoff_notice,
   output logic turnoffAck
);
   int waitCnt; // cycles spent draining after the notice
   // drain open work, then acknowledge and stay committed
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         waitCnt <= 0;
         turnoffAck <= 1'b0;
      end
      else if (turnoff_notice && !turnoffAck)
      begin
         waitCnt <= waitCnt + 1;
         if (waitCnt == ACK_DELAY)
            turnoffAck <= 1'b1;
      end
   end
endmodule

// ==== tb/link_power_and_irq_mode_ctrl_bench.sv ====
`timescale 1ns/1ns
module link_power_and_irq_mode_ctrl_bench;
   // apb and clock
   logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   // link and host side
   logic trainDone = 1'b0, turnoffMsg = 1'b0, l1AckDllp = 1'b0, l1ReqDllp, pmeToAckSend, ifClosed;
   lpm_pkg::lpm_link_t linkState;
   logic hostPmWr = 1'b0, hostIrqWr = 1'b0, hostMsiEn = 1'b0, hostMsixEn = 1'b0;
   logic [1:0] hostPmFunc = 2'h0, hostPmState = 2'h0;
   logic [15:0] hostCmd = 16'h0000;
   // user side
   logic reqValid = 1'b0, reqLast = 1'b0, linkReqReady = 1'b1, req_stream_ready;
   logic [7:0] funcPowerState;
   logic turnoff_notice, turnoffAck, msiEnable, msixEnable, intxMsgSend, msiWriteSend;
   logic userIntxReq = 1'b0, userMsiReq = 1'b0;
   lpm_pkg::lpm_irq_t irqMode;
   int bad_count = 0, total_checks = 0;

   lpm_ctrl dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .trainDone, .turnoffMsg, .l1AckDllp, .l1ReqDllp, .pmeToAckSend,
      .linkState, .ifClosed, .hostPmWr, .hostPmFunc, .hostPmState, .hostIrqWr, .hostMsiEn,
      .hostMsixEn, .hostCmd, .reqValid, .reqLast, .linkReqReady, .req_stream_ready,
      .funcPowerState, .turnoff_notice, .turnoffAck, .msiEnable, .msixEnable, .irqMode,
      .userIntxReq, .userMsiReq, .intxMsgSend, .msiWriteSend);
   lpm_user_model user (.core_clk, .sys_rst, .turnoff_notice, .turnoffAck);

   // free-running clock
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   // compare and count
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer, waits for pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      chk("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // host sets one function power state
   task pm(input logic [1:0] f, input logic [1:0] s);
      @(posedge core_clk);
      hostPmWr <= 1'b1;
      hostPmFunc <= f;
      hostPmState <= s;
      @(posedge core_clk);
      hostPmWr <= 1'b0;
   endtask

   // register reset, readback, unmapped access
   task test_regs;
      apb(1'b0, lpm_pkg::CTRL_OFFS, 32'h0);
      chk("ctrl reset", rd, {30'h0, lpm_pkg::CTRL_RESET});
      apb(1'b1, lpm_pkg::CTRL_OFFS, 32'h3);
      apb(1'b0, lpm_pkg::CTRL_OFFS, 32'h0);
      chk("ctrl", rd, 32'h3);
      apb(1'b0, lpm_pkg::STATUS_OFFS, 32'h0);
      chk("link up", rd[1:0], lpm_pkg::LNK_L0);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", err, 1'b1);
      $display("register test done");
   endtask

   // stall with an open packet, then l1 entry and exit
   task test_power;
      @(posedge core_clk);
      reqValid <= 1'b1;
      pm(2'h0, lpm_pkg::PWR_D3HOT);
      reqValid <= 1'b0;
      @(negedge core_clk);
      chk("power state", funcPowerState, 8'h03);
      chk("ready open packet", req_stream_ready, 1'b1);
      chk("link one low", linkState, lpm_pkg::LNK_L0);
      // power register shows the same states as the output
      apb(1'b0, lpm_pkg::POWER_OFFS, 32'h0);
      chk("power reg", rd, {30'h0, lpm_pkg::PWR_D3HOT});
      @(posedge core_clk);
      reqValid <= 1'b1;
      reqLast <= 1'b1;
      @(posedge core_clk);
      // user starts no new request while a function is outside D0
      reqValid <= 1'b0;
      @(negedge core_clk);
      chk("ready stalled", req_stream_ready, 1'b0);
      for (int f = 1; f < 4; f++)
         pm(f[1:0], lpm_pkg::PWR_D3HOT);
      for (int n = 0; n < 20 && l1ReqDllp !== 1'b1; n++)
         @(negedge core_clk);
      chk("l1 request", l1ReqDllp, 1'b1);
      @(posedge core_clk);
      l1AckDllp <= 1'b1;
      @(posedge core_clk);
      l1AckDllp <= 1'b0;
      @(negedge core_clk);
      chk("link l1", linkState, lpm_pkg::LNK_L1);
      for (int f = 0; f < 4; f++)
         pm(f[1:0], lpm_pkg::PWR_D0);
      repeat (2) @(negedge core_clk);
      chk("link back", linkState, lpm_pkg::LNK_L0);
      chk("ready back", req_stream_ready, 1'b1);
      $display("power test done");
   endtask

   // every enable and disable combination
   task test_irq;
      logic [2:0] j;
      for (int k = 0; k < 8; k++)
      begin
         j = k[2:0];
         @(posedge core_clk);
         hostIrqWr <= 1'b1;
         hostMsiEn <= j[0];
         hostMsixEn <= j[1];
         hostCmd <= {5'h00, j[2], 10'h000};
         @(posedge core_clk);
         hostIrqWr <= 1'b0;
         // user asks the built-in controller only for msi or legacy
         userMsiReq <= 1'b1;
         userIntxReq <= 1'b1;
         @(posedge core_clk);
         userMsiReq <= 1'b0;
         userIntxReq <= 1'b0;
         @(negedge core_clk);
         chk("msi enable", msiEnable, j[0]);
         chk("msix enable", msixEnable, j[1]);
         chk("irq mode", irqMode, j[1:0]);
         chk("msi write", msiWriteSend, j[0]);
         chk("intx message", intxMsgSend, j == 3'h0);
         apb(1'b0, lpm_pkg::STATUS_OFFS, 32'h0);
         chk("status irq", rd[7:3], {j[1:0], j[2], j[1], j[0]});
      end
      $display("interrupt test done");
   endtask

   // turnoff handshake into l23 ready
   task test_turnoff;
      @(posedge core_clk);
      turnoffMsg <= 1'b1;
      @(posedge core_clk);
      turnoffMsg <= 1'b0;
      @(negedge core_clk);
      chk("notice", turnoff_notice, 1'b1);
      // status register shows the pending notice
      apb(1'b0, lpm_pkg::STATUS_OFFS, 32'h0);
      chk("status notice", rd[2], 1'b1);
      chk("status link", rd[1:0], lpm_pkg::LNK_L0);
      for (int n = 0; n < 30 && pmeToAckSend !== 1'b1; n++)
      begin
         chk("notice held", turnoff_notice, 1'b1);
         @(negedge core_clk);
      end
      chk("ack message", pmeToAckSend, 1'b1);
      chk("notice dropped", turnoff_notice, 1'b0);
      @(negedge core_clk);
      chk("ack pulse", pmeToAckSend, 1'b0);
      chk("link l23", linkState, lpm_pkg::LNK_L23);
      chk("closed", ifClosed, 1'b1);
      chk("ready closed", req_stream_ready, 1'b0);
      $display("turnoff test done");
   endtask

   // reset in mid-run leaves l23 and restarts training
   task test_reset;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      chk("reset link", linkState, lpm_pkg::LNK_DOWN);
      chk("reset notice", turnoff_notice, 1'b0);
      chk("reset power", funcPowerState, 8'h00);
      chk("reset msi", msiEnable, 1'b0);
      chk("reset ready", req_stream_ready, 1'b1);
      @(negedge core_clk);
      chk("retrain link", linkState, lpm_pkg::LNK_L0);
      chk("reopened", ifClosed, 1'b0);
      $display("reset test done");
   endtask

   // verdict and end of run
   task test_done;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      trainDone <= 1'b1;
      repeat (4) @(posedge core_clk);
      test_regs();
      test_power();
      test_irq();
      test_turnoff();
      test_reset();
      test_done();
   end

   // watchdog, far beyond the expected run of about 120 cycles
   initial
   begin
      #100000;
      bad_count++;
      test_done();
   end
endmodule
